// [pkg/sector_lock_pkg.sv]
// shared constants, command codes and field layout for the sector lock block
// assumes one clock domain and a host on the same clock issuing lock commands
// Functional notes
// [R1] one nonvolatile bit per sector; 0 blocks program and erase, survives reset
// [R2] program-nonvolatile-lock clears the addressed sector bit to 0, byte-program long
// [R3] erase-nonvolatile-locks sets every sector bit back to 1, sector-erase long
// [R4] read-nonvolatile-locks returns the addressed sector nonvolatile bit
// [R5] volatile write-lock bit 0 at 1 blocks program and erase of the sector
// [R6] write-volatile-locks loads the addressed volatile register; 1 sets write-lock
// [R7] any reset clears every volatile lock bit of every sector to 0
// [R8] read-volatile-locks returns the addressed volatile register
// [R9] write-volatile-locks runs only while lock-down bit 1 is 0, else ignored
// [R10] lock-down at 1 refuses writes to both volatile bits until power cycle; the code also clears it on sys_rst
// [R11] power-up leaves lock-down and write-lock of every sector at 0
// [R12] nonvolatile program and erase rejected while global freeze is 0
// [R13] first and last sectors carry volatile locks per 4KB subsector
// [R14] sector protected when nonvolatile bit is 0 or write-lock is 1
// [R15] upper six bits of each volatile register read as 0
package sector_lock_pkg;

    typedef enum logic [2:0] {
        OP_RD_NV    = 3'h0,
        OP_PROG_NV  = 3'h1,
        OP_ERASE_NV = 3'h2,
        OP_RD_V     = 3'h3,
        OP_WR_V     = 3'h4
    } cmd_op_t;

    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          NUM_SECT_DEF    = 512;
    localparam int          SUB_PER_SECT    = 16;
    localparam int          SUB_W           = 4;
    localparam int          PROG_TIME_NS    = 1000;
    localparam int          ERASE_TIME_NS   = 1000000;
    localparam int          VLK_WL_BIT      = 0;
    localparam int          VLK_LD_BIT      = 1;
    localparam logic [1:0]  VLK_RESET       = 2'h0;
    localparam logic        NV_LOCKED       = 1'b0;
    localparam logic        NV_OPEN         = 1'b1;

endpackage : sector_lock_pkg

// [design/sector_lock_protection.sv]
// per-sector nonvolatile and volatile write protection with a lock command port
// assumes host logic on mclk; commands taken only while cmd_ready is high
module sector_lock_protection #(
    parameter int NUM_SECT      = sector_lock_pkg::NUM_SECT_DEF,
    parameter int PROG_TIME_NS  = sector_lock_pkg::PROG_TIME_NS,
    parameter int ERASE_TIME_NS = sector_lock_pkg::ERASE_TIME_NS,
    parameter int SECT_W        = $clog2(NUM_SECT)
) (
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire logic                         cmd_valid,
    input  wire sector_lock_pkg::cmd_op_t     cmd_op,
    input  wire logic [SECT_W-1:0]            cmd_sect,
    input  wire logic [sector_lock_pkg::SUB_W-1:0] cmd_sub,
    input  wire logic [7:0]                   cmd_wdata,
    input  wire logic                         global_freeze,
    input  wire logic [SECT_W-1:0]            chk_sect,
    input  wire logic [sector_lock_pkg::SUB_W-1:0] chk_sub,
    output logic                              cmd_ready,
    output logic                              rsp_valid,
    output logic [7:0]                        rsp_data,
    output logic                              cmd_reject,
    output logic                              chk_prot
);
    import sector_lock_pkg::*;

    // ============================================================
    // sizing and timing
    localparam int NV_ENT    = NUM_SECT - 2 + 2 * SUB_PER_SECT;
    localparam int VI_W      = $clog2(NV_ENT);
    localparam int PROG_CYC  = ((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                               (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYC = ((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                               (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {ST_IDLE, ST_BUSY} state_t;

    // [R13] subsector map: end sectors get one volatile entry per 4KB subsector
    function automatic logic [VI_W-1:0] vidx(input logic [SECT_W-1:0] s,
                                             input logic [SUB_W-1:0]  b);
        logic [31:0] r;
        r = 32'(s) + 32'(SUB_PER_SECT - 1);
        if (s == '0)
            r = 32'(b);
        else if (32'(s) == 32'(NUM_SECT - 1))
            r = 32'(NUM_SECT + SUB_PER_SECT - 2) + 32'(b);
        return r[VI_W-1:0];
    endfunction

    // ============================================================
    // storage
    // nonvolatile bits ignore sys_rst; they start open, as shipped
    logic [NUM_SECT-1:0] nv_r = '1;
    logic [1:0]          vlk_r [NV_ENT];

    state_t              state_r;
    cmd_op_t             op_r;
    logic [SECT_W-1:0]   sect_r;
    logic [31:0]         cnt_r;
    logic                cmd_ready_r;
    logic                rsp_valid_r;
    logic [7:0]          rsp_data_r;
    logic                rej_r;
    logic                chk_prot_r;

    logic                accept;
    logic [VI_W-1:0]     cidx;
    logic [1:0]          v_sel;
    logic                nv_sel;
    logic                v_we;
    logic                nv_start;
    logic                nv_done;
    logic                nv_chk;
    logic [1:0]          v_chk;
    logic                prot_nxt;

    assign accept   = cmd_valid && cmd_ready_r;
    assign cidx     = vidx(cmd_sect, cmd_sub);
    assign v_sel    = vlk_r[cidx];
    assign nv_sel   = nv_r[cmd_sect];
    // [R12] freeze gate on nonvolatile ops
    assign nv_start = accept && global_freeze &&
                      (cmd_op == OP_PROG_NV || cmd_op == OP_ERASE_NV);
    // [R9] lock-down gate on volatile writes
    assign v_we     = accept && (cmd_op == OP_WR_V) && !v_sel[VLK_LD_BIT];
    assign nv_done  = (state_r == ST_BUSY) && (cnt_r == 32'h0);

    // ============================================================
    // command sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r     <= ST_IDLE;
            op_r        <= OP_RD_NV;
            sect_r      <= '0;
            cnt_r       <= 32'h0;
            cmd_ready_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cmd_ready_r <= 1'b1;
                    if (nv_start) begin
                        state_r     <= ST_BUSY;
                        op_r        <= cmd_op;
                        sect_r      <= cmd_sect;
                        cmd_ready_r <= 1'b0;
                        cnt_r       <= (cmd_op == OP_PROG_NV) ? 32'(PROG_CYC - 1)
                                                              : 32'(ERASE_CYC - 1);
                    end
                end
                ST_BUSY: begin
                    if (nv_done) begin
                        state_r     <= ST_IDLE;
                        cmd_ready_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                default: begin
                    state_r     <= ST_IDLE;
                    cmd_ready_r <= 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // nonvolatile bits, committed when the timed operation ends
    // an abort by reset leaves the bits untouched, like a cut-off program pulse
    always_ff @(posedge mclk) begin
        if (!sys_rst && nv_done) begin
            // [R2] program clears one bit
            if (op_r == OP_PROG_NV)
                nv_r[sect_r] <= NV_LOCKED;
            // [R3] erase opens all
            else
                nv_r <= '1;
        end
    end

    // ============================================================
    // volatile lock registers, one per sector or end subsector
    for (genvar i = 0; i < NV_ENT; i++) begin : g_vlk
        always_ff @(posedge mclk) begin
            // [R7] [R11] reset clears all
            if (sys_rst)
                vlk_r[i] <= VLK_RESET;
            // [R6] [R10] guarded update
            else if (v_we && cidx == VI_W'(i))
                vlk_r[i] <= cmd_wdata[1:0];
        end
    end

    // ============================================================
    // answers to reads and refusals
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= 8'h00;
            rej_r       <= 1'b0;
        end else begin
            rsp_valid_r <= accept && (cmd_op == OP_RD_NV || cmd_op == OP_RD_V);
            rej_r       <= accept && !nv_start && !v_we &&
                           (cmd_op == OP_PROG_NV || cmd_op == OP_ERASE_NV ||
                            cmd_op == OP_WR_V);
            // [R4] nonvolatile readback
            if (accept && cmd_op == OP_RD_NV)
                rsp_data_r <= {7'h00, nv_sel};
            // [R8] [R15] volatile readback
            else if (accept && cmd_op == OP_RD_V)
                rsp_data_r <= {6'h00, v_sel};
        end
    end

    // ============================================================
    // protection query for the program/erase engine
    assign nv_chk   = nv_r[chk_sect];
    assign v_chk    = vlk_r[vidx(chk_sect, chk_sub)];
    // [R1] [R5] [R14] either guard protects
    assign prot_nxt = (nv_chk == NV_LOCKED) || v_chk[VLK_WL_BIT];

    always_ff @(posedge mclk) begin
        if (sys_rst)
            chk_prot_r <= 1'b0;
        else
            chk_prot_r <= prot_nxt;
    end

    assign cmd_ready  = cmd_ready_r;
    assign rsp_valid  = rsp_valid_r;
    assign rsp_data   = rsp_data_r;
    assign cmd_reject = rej_r;
    assign chk_prot   = chk_prot_r;

    // ============================================================
    // checks
    logic [VI_W-1:0] widx_q_r;
    logic [1:0]      vw_q;
    logic [1:0]      wv_bits;

    always_ff @(posedge mclk) begin
        if (sys_rst)
            widx_q_r <= '0;
        else if (accept)
            widx_q_r <= cidx;
    end
    assign vw_q    = vlk_r[widx_q_r];
    assign wv_bits = cmd_wdata[1:0];

    a_nv_prog_clear: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
        nv_done && op_r == OP_PROG_NV |=> nv_r[sect_r] == NV_LOCKED)
        else $error("program did not lock the sector");
    a_nv_erase_all: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
        nv_done && op_r == OP_ERASE_NV |=> (&nv_r))
        else $error("erase left a sector locked");
    a_freeze_reject: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
        accept && !global_freeze && (cmd_op == OP_PROG_NV || cmd_op == OP_ERASE_NV)
        |=> rej_r && cmd_ready_r && state_r == ST_IDLE)
        else $error("nonvolatile op ran while frozen");
    a_prog_time: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
        nv_start && cmd_op == OP_PROG_NV |=> !cmd_ready_r [*1] ##(PROG_CYC) cmd_ready_r)
        else $error("program busy time wrong");
    // a busy engine must not take a command or answer a read
    a_busy_blocked: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
        state_r == ST_BUSY |-> !cmd_ready_r && !rsp_valid_r)
        else $error("command taken during nonvolatile operation");
    a_rd_nv_data: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
        accept && cmd_op == OP_RD_NV |=> rsp_valid_r && rsp_data_r == {7'h00, $past(nv_sel)})
        else $error("nonvolatile readback wrong");
    a_rd_v_data: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
        accept && cmd_op == OP_RD_V |=> rsp_valid_r && rsp_data_r == {6'h00, $past(v_sel)})
        else $error("volatile readback wrong");
    a_wr_v_update: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
        v_we |=> vw_q == $past(wv_bits))
        else $error("volatile write not stored");
    a_lockdown_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [R10]
        accept && cmd_op == OP_WR_V && v_sel[VLK_LD_BIT] |=> vw_q == $past(v_sel) && rej_r)
        else $error("locked-down register changed");
    a_vol_reset: assert property (@(posedge mclk) // [R7]
        sys_rst |=> vw_q == VLK_RESET && v_sel == VLK_RESET && v_chk == VLK_RESET &&
                    !chk_prot_r)
        else $error("volatile bits survived reset");
    a_prot_nv: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
        nv_chk == NV_LOCKED |=> chk_prot_r)
        else $error("nonvolatile lock not honoured");
    a_prot_vol: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
        v_chk[VLK_WL_BIT] |=> chk_prot_r)
        else $error("write-lock not honoured");
    a_prot_free: assert property (@(posedge mclk) disable iff (sys_rst) // [R14]
        nv_chk == NV_OPEN && !v_chk[VLK_WL_BIT] |=> !chk_prot_r)
        else $error("sector protected without cause");

    c_prog_done:  cover property (@(posedge mclk) disable iff (sys_rst)
        nv_done && op_r == OP_PROG_NV);
    c_erase_done: cover property (@(posedge mclk) disable iff (sys_rst)
        nv_done && op_r == OP_ERASE_NV);
    c_lockdown:   cover property (@(posedge mclk) disable iff (sys_rst)
        v_we && wv_bits == 2'h3);
    c_refused:    cover property (@(posedge mclk) disable iff (sys_rst)
        rej_r);

endmodule // sector_lock_protection

// [dv/lock_host.sv]
// host model that issues lock commands on the command port
// assumes callers step at 1 ns after a rising mclk edge
module lock_host
    import sector_lock_pkg::*;
#(
    parameter int SECT_W = 3
) (
    input  wire logic                      mclk,
    input  wire logic                      cmd_ready,
    input  wire logic                      rsp_valid,
    input  wire logic [7:0]                rsp_data,
    input  wire logic                      cmd_reject,
    output logic                           cmd_valid,
    output sector_lock_pkg::cmd_op_t       cmd_op,
    output logic [SECT_W-1:0]              cmd_sect,
    output logic [sector_lock_pkg::SUB_W-1:0] cmd_sub,
    output logic [7:0]                     cmd_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = OP_RD_NV;
        cmd_sect  = '0;
        cmd_sub   = '0;
        cmd_wdata = 8'h00;
    end
    // =========================================================
    // one command: held until a ready edge, answer taken 1 ns after that same edge
    task automatic send(input cmd_op_t op, input logic [SECT_W-1:0] s,
                        input logic [SUB_W-1:0] sb, input logic [7:0] wd,
                        output logic [7:0] rd, output logic rv, output logic rj,
                        output logic tmo);
        int n;
        n = 0;
        cmd_op    = op;
        cmd_sect  = s;
        cmd_sub   = sb;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        // ready checked 1 ns after an edge so the next edge is the taking edge
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        tmo = (n >= 200);
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
        rd = rsp_data;
        rv = rsp_valid;
        rj = cmd_reject;
        // one idle edge so cmd_valid never falls and rises in one time step
        @(posedge mclk);
        #1;
    endtask
endmodule // lock_host

// [dv/sector_lock_protection_bench.sv]
// self-checking bench for the sector lock block
// assumes 8 sectors, short nonvolatile timings, host model on the command port
module sector_lock_protection_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import sector_lock_pkg::*;
    localparam int SW = 3;
    logic          mclk = 1'b0;
    logic          sys_rst = 1'b1;
    logic          global_freeze = 1'b0;
    logic [SW-1:0] chk_sect = '0;
    logic [3:0]    chk_sub = '0;
    logic          cmd_valid, cmd_ready, rsp_valid, cmd_reject, chk_prot;
    cmd_op_t       cmd_op;
    logic [SW-1:0] cmd_sect;
    logic [3:0]    cmd_sub;
    logic [7:0]    cmd_wdata, rsp_data, rd;
    logic          rv, rj;
    int            err_count = 0;
    int            n_checks = 0;
    always #4 mclk = ~mclk;
    // =========================================================
    sector_lock_protection #(.NUM_SECT(8), .PROG_TIME_NS(128), .ERASE_TIME_NS(320))
    u_sector_lock_protection (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_sect(cmd_sect), .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata),
        .global_freeze(global_freeze), .chk_sect(chk_sect), .chk_sub(chk_sub),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .cmd_reject(cmd_reject), .chk_prot(chk_prot));
    lock_host #(.SECT_W(SW)) u_lock_host (.mclk(mclk), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_reject(cmd_reject),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sect(cmd_sect), .cmd_sub(cmd_sub),
        .cmd_wdata(cmd_wdata));
    // =========================================================
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input cmd_op_t op, input logic [SW-1:0] s, input logic [3:0] sb,
                       input logic [7:0] wd);
        logic tmo;
        u_lock_host.send(op, s, sb, wd, rd, rv, rj, tmo);
        if (tmo) begin
            err_count++;
            $display("CHECK FAILED t=%0t ready wait ran out", $time);
            end_sim();
        end
    endtask
    task automatic rdv(input logic [SW-1:0] s, input logic [3:0] sb, input logic [7:0] e);
        run(OP_RD_V, s, sb, 8'h00);
        chk({7'h00, rv}, 8'h01);
        chk(rd, e);
    endtask
    task automatic rdnv(input logic [SW-1:0] s, input logic e);
        run(OP_RD_NV, s, 4'h0, 8'h00);
        chk({7'h00, rv}, 8'h01);
        chk(rd, {7'h00, e});
    endtask
    // protection answer lands one edge after the query
    task automatic prot(input logic [SW-1:0] s, input logic [3:0] sb, input logic e);
        chk_sect = s;
        chk_sub  = sb;
        @(posedge mclk);
        #1;
        chk({7'h00, chk_prot}, {7'h00, e});
    endtask
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
    endtask
    // =========================================================
    task automatic t_volatile();
        rdv(3'h3, 4'h0, 8'h00);
        rdnv(3'h3, 1'b1);
        run(OP_WR_V, 3'h3, 4'h0, 8'hFD);
        rdv(3'h3, 4'h0, 8'h01);
        prot(3'h3, 4'h0, 1'b1);
        prot(3'h2, 4'h0, 1'b0);
        run(OP_WR_V, 3'h2, 4'h0, 8'h03);
        run(OP_WR_V, 3'h2, 4'h0, 8'h00);
        chk({7'h00, rj}, 8'h01);
        rdv(3'h2, 4'h0, 8'h03);
        run(OP_WR_V, 3'h7, 4'h9, 8'h01);
        rdv(3'h7, 4'h8, 8'h00);
        rdv(3'h7, 4'h9, 8'h01);
        prot(3'h7, 4'h9, 1'b1);
        run(OP_WR_V, 3'h0, 4'h5, 8'h01);
        rdv(3'h0, 4'h4, 8'h00);
        rdv(3'h0, 4'h5, 8'h01);
        prot(3'h0, 4'h5, 1'b1);
        prot(3'h0, 4'h4, 1'b0);
        $display("test volatile done");
    endtask
    task automatic t_nonvolatile();
        global_freeze = 1'b0;
        run(OP_PROG_NV, 3'h4, 4'h0, 8'h00);
        chk({7'h00, rj}, 8'h01);
        rdnv(3'h4, 1'b1);
        run(OP_ERASE_NV, 3'h0, 4'h0, 8'h00);
        chk({7'h00, rj}, 8'h01);
        global_freeze = 1'b1;
        run(OP_PROG_NV, 3'h4, 4'h0, 8'h00);
        chk({7'h00, cmd_ready}, 8'h00);
        rdnv(3'h4, 1'b0);
        prot(3'h4, 4'h0, 1'b1);
        $display("test nonvolatile done");
    endtask
    task automatic t_reset();
        do_reset();
        rdv(3'h2, 4'h0, 8'h00);
        rdv(3'h3, 4'h0, 8'h00);
        rdv(3'h7, 4'h9, 8'h00);
        rdv(3'h0, 4'h5, 8'h00);
        rdnv(3'h4, 1'b0);
        run(OP_WR_V, 3'h2, 4'h0, 8'h01);
        chk({7'h00, rj}, 8'h00);
        run(OP_ERASE_NV, 3'h0, 4'h0, 8'h00);
        rdnv(3'h4, 1'b1);
        prot(3'h4, 4'h0, 1'b0);
        $display("test reset and erase done");
    endtask
    initial begin
        do_reset();
        t_volatile();
        t_nonvolatile();
        t_reset();
        end_sim();
    end
endmodule // sector_lock_protection_bench
